/* File: src/rcb_pkg.sv */
// package for the receive signaling buffer: register map, field layout,
// line formats, frame lengths and the bus carriers.
// assumes a 32-bit axi4-lite master and a frame-aligned receive stream.
package rcb_pkg;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [7:0] REG_CFG     = 8'h00;
  localparam logic [7:0] REG_BUSY    = 8'h04;
  localparam logic [7:0] REG_ACC_CTL = 8'h08;
  localparam logic [7:0] REG_ACC_DAT = 8'h0C;
  localparam logic [7:0] REG_COS     = 8'h10;
  localparam logic [7:0] REG_COS_MSK = 8'h14;
  localparam logic [7:0] REG_LINK    = 8'h18;

  // configuration fields
  localparam int CFG_DEB = 0;
  localparam int CFG_FRZ = 1;
  localparam int CFG_SIX = 2;
  localparam int CFG_IRQ = 3;
  localparam int CFG_E1  = 4;
  localparam int CFG_FMT = 5;

  // indirect word: extract enable on top, code in low nibble (a = bit 3)
  localparam int IND_EXT    = 7;
  localparam int ACC_RNW    = 7;
  localparam logic [6:0] IND_T1_LAST = 7'h18;
  localparam logic [6:0] IND_E1_LAST = 7'h1F;
  localparam logic [6:0] IND_E1_HOLE = 7'h10;

  // reset value and bus response codes
  localparam logic [31:0] COS_MSK_RST = 32'hFFFFFFFF;
  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;

  // frame and multiframe geometry
  localparam logic [8:0] T1_FRAME_LAST = 9'h0C0;
  localparam logic [8:0] E1_FRAME_LAST = 9'h0FF;
  localparam logic [2:0] SIG_FRAME_SIX = 3'h5;
  localparam logic [4:0] E1_SIG_TS     = 5'h10;

  typedef enum logic [1:0] {
    FMT_SF    = 2'b00,
    FMT_ESF   = 2'b01,
    FMT_SLC96 = 2'b10,
    FMT_DM    = 2'b11
  } rcb_fmt_t;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } rcb_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } rcb_axi_rsp_t;

endpackage : rcb_pkg

/* File: src/rcb_sync.sv */
// two-flop level synchroniser, one per bit of the bus.
// assumes inputs are slow levels compared with aclk.
`timescale 1ns/1ps
`default_nettype none
module rcb_sync #(
  parameter int W = 1
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  // first stage feeds only the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule : rcb_sync
`default_nettype wire

/* File: src/rcb_top.sv */
// receive signaling buffer: pulls robbed-bit / cas codes out of the
// received stream, stores them per channel and drives the serial
// signaling output aligned with the data output.
// assumes the link clock, line data and status pins are asynchronous.
//
// Function
// - t1 signaling from bit 8 of frames 6n
// - ab/abcd code in slot low nibble
// - extract-enabled channels store received code bits
// - superframe copies a,b into c,d
// - dm format performs no extraction
// - debounce: update after two identical codes
// - freeze on sync loss, slip, software freeze
// - four-state: frames 6,18 a; 12,24 b
// - sixteen-state stores a,b,c,d
// - stored code change sets per-channel flag
// - enabled interrupt low while an unmasked flag set
// - indirect access: address, direction, data, busy
// - e1 signaling taken from timeslot 16
// - e1 code in timeslot low nibble
// - e1 also freezes on multiframe sync loss
// - indirect map t1 1-18h, e1 1-fh,11-1fh
`timescale 1ns/1ps
`default_nettype none
module rcb_top (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire rcb_pkg::rcb_axi_req_t axi_req,
  output var  rcb_pkg::rcb_axi_rsp_t axi_rsp,
  input  wire logic                  rx_link_clk,
  input  wire logic                  rx_line_data,
  input  wire logic                  rx_mf_start,
  input  wire logic                  frame_sync_lost,
  input  wire logic                  smf_sync_lost,
  input  wire logic                  es_slip,
  output var  logic                  rx_data_out,
  output var  logic                  rx_signaling_out,
  output var  logic                  int_n
);
  import rcb_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic               lclk_prev;
    logic [8:0]         pos;
    logic [2:0]         f6;
    logic [1:0]         stage;
    logic [3:0]         e1_frm;
    logic [31:0][3:0]   sig;
    logic [31:0]        ext;
    logic [31:0][3:0]   asm_code;
    logic [31:0][3:0]   last_code;
    logic [31:0]        cos;
    logic [31:0]        cos_msk;
    logic               debounce_enable;
    logic               freeze;
    logic               sixteen_state_select;
    logic               signaling_irq_enable;
    logic               e1_mode;
    rcb_fmt_t           fmt;
    logic               slip_hold;
    logic [6:0]         ind_addr;
    logic               indirect_read_not_write;
    logic [7:0]         ind_data;
    logic               busy;
    logic               awready;
    logic               wready;
    logic               aw_got;
    logic               w_got;
    logic [7:0]         awaddr;
    logic [31:0]        wdata;
    logic [3:0]         wstrb;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               arready;
    logic               rvalid;
    logic [31:0]        rdata;
    logic [1:0]         rresp;
    logic               data_out;
    logic               sig_out;
    logic               int_n;
  } rcb_state_t;

  rcb_state_t q;
  rcb_state_t d;

  // ****************************************
  // input synchronisers
  // ****************************************
  logic [5:0] pins_s;
  logic       s_lclk;
  logic       s_data;
  logic       s_mf;
  logic       s_fsl;
  logic       s_smfl;
  logic       s_slip;

  rcb_sync #(.W(6)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({rx_link_clk, rx_line_data, rx_mf_start,
               frame_sync_lost, smf_sync_lost, es_slip}),
    .q       (pins_s)
  );

  assign {s_lclk, s_data, s_mf, s_fsl, s_smfl, s_slip} = pins_s;

  // ****************************************
  // helpers
  // ****************************************
  // byte lanes without a strobe keep their old value
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // indirect address valid for the current line mode
  function automatic logic ind_mapped(input logic [6:0] a, input logic e1);
    logic r;
    r = 1'b0;
    if (e1) begin
      r = (a != 7'h00) && (a <= IND_E1_LAST) && (a != IND_E1_HOLE);
    end else begin
      r = (a != 7'h00) && (a <= IND_T1_LAST);
    end
    return r;
  endfunction : ind_mapped

  // ****************************************
  // next-state logic
  // ****************************************
  logic [31:0] cos_set;
  logic [31:0] cos_clr;
  logic [31:0] cfg_rd;
  logic [31:0] wr_val;
  logic [8:0]  pos;
  logic [8:0]  pm1;
  logic [2:0]  f6;
  logic [1:0]  stg;
  logic [3:0]  ef;
  logic [4:0]  slot;
  logic [2:0]  bitp;
  logic [1:0]  letter;
  logic [3:0]  code;
  logic [4:0]  ti;
  logic        sample;
  logic        frz_now;
  logic        last_stage;
  logic        commit;
  logic [8:0]  frame_last;

  always_comb begin
    d          = q;
    cos_set    = '0;
    cos_clr    = '0;
    cfg_rd     = '0;
    wr_val     = '0;
    pos        = q.pos;
    pm1        = '0;
    f6         = q.f6;
    stg        = q.stage;
    ef         = q.e1_frm;
    slot       = '0;
    bitp       = '0;
    letter     = '0;
    code       = '0;
    ti         = '0;
    commit     = 1'b0;
    last_stage = 1'b0;
    frame_last = q.e1_mode ? E1_FRAME_LAST : T1_FRAME_LAST;
    sample     = s_lclk && !q.lclk_prev;
    d.lclk_prev = s_lclk;

    cfg_rd[CFG_DEB]          = q.debounce_enable;
    cfg_rd[CFG_FRZ]          = q.freeze;
    cfg_rd[CFG_SIX]          = q.sixteen_state_select;
    cfg_rd[CFG_IRQ]          = q.signaling_irq_enable;
    cfg_rd[CFG_E1]           = q.e1_mode;
    cfg_rd[CFG_FMT +: 2]     = q.fmt;

    // slip freezes the rest of the multiframe it hit
    frz_now = q.freeze || q.slip_hold || s_slip || s_fsl
              || (q.e1_mode && s_smfl);
    if (s_slip) begin
      d.slip_hold = 1'b1;
    end else if (sample && s_mf) begin
      d.slip_hold = 1'b0;
    end

    // axi write channel: address and data taken in either order
    if (axi_req.awvalid && q.awready) begin
      d.aw_got  = 1'b1;
      d.awready = 1'b0;
      d.awaddr  = axi_req.awaddr;
    end
    if (axi_req.wvalid && q.wready) begin
      d.w_got  = 1'b1;
      d.wready = 1'b0;
      d.wdata  = axi_req.wdata;
      d.wstrb  = axi_req.wstrb;
    end
    if (q.aw_got && q.w_got && !q.bvalid) begin
      d.aw_got = 1'b0;
      d.w_got  = 1'b0;
      d.bvalid = 1'b1;
      d.bresp  = RESP_OKAY;
      unique case (q.awaddr)
        REG_CFG: begin
          wr_val                 = merge(cfg_rd, q.wdata, q.wstrb);
          d.debounce_enable      = wr_val[CFG_DEB];
          d.freeze               = wr_val[CFG_FRZ];
          d.sixteen_state_select = wr_val[CFG_SIX];
          d.signaling_irq_enable = wr_val[CFG_IRQ];
          d.e1_mode              = wr_val[CFG_E1];
          d.fmt                  = rcb_fmt_t'(wr_val[CFG_FMT +: 2]);
        end
        REG_ACC_CTL: begin
          // a new access while busy is dropped
          if (!q.busy && q.wstrb[0]) begin
            d.ind_addr                = q.wdata[6:0];
            d.indirect_read_not_write = q.wdata[ACC_RNW];
            d.busy                    = 1'b1;
          end
        end
        REG_ACC_DAT: begin
          if (q.wstrb[0]) begin
            d.ind_data = q.wdata[7:0];
          end
        end
        REG_COS: begin
          cos_clr = merge('0, q.wdata, q.wstrb);
        end
        REG_COS_MSK: begin
          d.cos_msk = merge(q.cos_msk, q.wdata, q.wstrb);
        end
        REG_BUSY, REG_LINK: begin
        end
        default: begin
          d.bresp = RESP_SLVERR;
        end
      endcase
    end
    if (q.bvalid && axi_req.bready) begin
      d.bvalid  = 1'b0;
      d.awready = 1'b1;
      d.wready  = 1'b1;
    end

    // axi read channel
    if (axi_req.arvalid && q.arready) begin
      d.arready = 1'b0;
      d.rvalid  = 1'b1;
      d.rresp   = RESP_OKAY;
      d.rdata   = '0;
      unique case (axi_req.araddr)
        REG_CFG:     d.rdata = cfg_rd;
        REG_BUSY:    d.rdata[0] = q.busy;
        REG_ACC_CTL: d.rdata[7:0] = {q.indirect_read_not_write, q.ind_addr};
        REG_ACC_DAT: d.rdata[7:0] = q.ind_data;
        REG_COS: begin
          d.rdata = q.cos;
          cos_clr = cos_clr | q.cos;                                // read clears
        end
        REG_COS_MSK: d.rdata = q.cos_msk;
        REG_LINK:    d.rdata[2:0] = {q.slip_hold, s_smfl, s_fsl};
        default: begin
          d.rresp = RESP_SLVERR;
        end
      endcase
    end
    if (q.rvalid && axi_req.rready) begin
      d.rvalid  = 1'b0;
      d.arready = 1'b1;
    end

    // link side: one step per rising edge of the sampled link clock
    if (sample) begin
      if (s_mf) begin
        pos = '0;
        f6  = '0;
        stg = '0;
        ef  = '0;
      end
      pm1  = 9'(pos - 9'h001);
      if (q.e1_mode) begin
        slot = pos[7:3];
        bitp = pos[2:0];
      end else begin
        slot = 5'(pm1[7:3]) + 5'h01;
        bitp = pm1[2:0];
      end
      d.data_out = s_data;
      // low nibble carries a..d, bit 8 of the slot is d
      d.sig_out  = 1'b0;
      if (bitp[2] && (q.e1_mode || pos != 9'h000)) begin
        d.sig_out = q.sig[slot][2'd3 - bitp[1:0]];
      end
      if (q.e1_mode && (slot == 5'h00 || slot == E1_SIG_TS)) begin
        d.sig_out = 1'b0;
      end

      if (!q.e1_mode && q.fmt != FMT_DM && pos != 9'h000
          && bitp == 3'h7 && f6 == SIG_FRAME_SIX) begin
        ti = slot;
        if (q.fmt == FMT_SF) begin
          letter     = stg;
          last_stage = (stg == 2'h1);
        end else begin
          letter     = q.sixteen_state_select ? stg : {1'b0, stg[0]};
          last_stage = (stg == 2'h3);
        end
        code = q.asm_code[ti];
        code[2'd3 - letter] = s_data;
        if (q.fmt == FMT_SF || !q.sixteen_state_select) begin
          code[2'd1 - letter[0]] = s_data;
        end
        d.asm_code[ti] = code;
        commit = last_stage;
      end

      if (q.e1_mode && slot == E1_SIG_TS && ef != 4'h0) begin
        ti     = bitp[2] ? {1'b1, ef} : {1'b0, ef};
        letter = bitp[1:0];
        code   = q.asm_code[ti];
        code[2'd3 - letter] = s_data;
        d.asm_code[ti] = code;
        commit = (letter == 2'h3);
      end

      // store, debounce and change detection
      if (commit && q.ext[ti] && !frz_now) begin
        d.last_code[ti] = code;
        if (!q.debounce_enable || q.last_code[ti] == code) begin
          d.sig[ti] = code;
          if (q.sig[ti] != code) begin
            cos_set[ti] = 1'b1;
          end
        end
      end

      // advance bit, frame and multiframe counters
      if (pos == frame_last) begin
        pos = '0;
        ef  = 4'(ef + 4'h1);
        if (f6 == SIG_FRAME_SIX) begin
          f6  = '0;
          stg = (q.fmt == FMT_SF && stg == 2'h1) ? 2'h0 : 2'(stg + 2'h1);
        end else begin
          f6 = 3'(f6 + 3'h1);
        end
      end else begin
        pos = 9'(pos + 9'h001);
      end
      d.pos    = pos;
      d.f6     = f6;
      d.stage  = stg;
      d.e1_frm = ef;
    end

    // indirect access completes one cycle after it starts
    if (q.busy) begin
      d.busy = 1'b0;
      if (q.indirect_read_not_write) begin
        d.ind_data = '0;
        if (ind_mapped(q.ind_addr, q.e1_mode)) begin
          d.ind_data[IND_EXT] = q.ext[q.ind_addr[4:0]];
          d.ind_data[3:0]     = d.sig[q.ind_addr[4:0]];
        end
      end else if (ind_mapped(q.ind_addr, q.e1_mode)) begin
        d.ext[q.ind_addr[4:0]] = q.ind_data[IND_EXT];
        d.sig[q.ind_addr[4:0]] = q.ind_data[3:0];
      end
    end

    // a flag set in the cycle of its clear stays set
    d.cos   = (q.cos & ~cos_clr) | cos_set;
    d.cos[0] = 1'b0;
    d.int_n = !(q.signaling_irq_enable && |(d.cos & q.cos_msk));
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q         <= '0;
      q.cos_msk <= COS_MSK_RST;
      q.awready <= 1'b1;
      q.wready  <= 1'b1;
      q.arready <= 1'b1;
      q.int_n   <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ****************************************
  // outputs, all straight from flops
  // ****************************************
  assign axi_rsp.awready   = q.awready;
  assign axi_rsp.wready    = q.wready;
  assign axi_rsp.bvalid    = q.bvalid;
  assign axi_rsp.bresp     = q.bresp;
  assign axi_rsp.arready   = q.arready;
  assign axi_rsp.rvalid    = q.rvalid;
  assign axi_rsp.rdata     = q.rdata;
  assign axi_rsp.rresp     = q.rresp;
  assign rx_data_out       = q.data_out;
  assign rx_signaling_out  = q.sig_out;
  assign int_n             = q.int_n;

endmodule : rcb_top
`default_nettype wire

/* File: tb/rcb_properties.sv */
// checker for the receive signaling buffer top: bus timing, unmapped
// answers, reset levels and quiet outputs between link edges.
// assumes it is bound onto rcb_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module rcb_properties (
  input wire logic                  aclk,
  input wire logic                  aresetn,
  input wire rcb_pkg::rcb_axi_req_t axi_req,
  input wire rcb_pkg::rcb_axi_rsp_t axi_rsp,
  input wire logic                  rx_link_clk,
  input wire logic                  rx_data_out,
  input wire logic                  rx_signaling_out,
  input wire logic                  int_n
);
  import rcb_pkg::*;
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // address and data taken at one edge
  logic both_hs;
  assign both_hs = axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;

  wr_time_a: assert property (both_hs |=> !axi_rsp.bvalid ##1 axi_rsp.bvalid)
    else $error("write response not two cycles after handshake");
  b_hold_a: assert property (
    axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
    else $error("write response dropped before bready");
  rd_time_a: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
    else $error("read data not one cycle after handshake");
  r_hold_a: assert property (
    axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
    else $error("read data changed before rready");
  ar_block_a: assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
    else $error("read address taken while data pending");
  rd_unmapped_a: assert property (
    axi_req.arvalid && axi_rsp.arready && axi_req.araddr > REG_LINK
    |=> axi_rsp.rresp == RESP_SLVERR && axi_rsp.rdata == 32'h00000000)
    else $error("unmapped read not refused");
  wr_unmapped_a: assert property (
    both_hs && axi_req.awaddr > REG_LINK |-> ##2 axi_rsp.bresp == RESP_SLVERR)
    else $error("unmapped write not refused");
  // outputs only step on a link edge, so a long low phase is quiet
  link_quiet_a: assert property (
    !rx_link_clk [*6] |-> $stable(rx_data_out) && $stable(rx_signaling_out))
    else $error("serial output moved without a link edge");
  rst_level_a: assert property ($rose(aresetn) |-> int_n && !rx_signaling_out)
    else $error("interrupt or signaling active out of reset");
endmodule : rcb_properties

bind rcb_top rcb_properties u_props (
  .aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp),
  .rx_link_clk(rx_link_clk), .rx_data_out(rx_data_out),
  .rx_signaling_out(rx_signaling_out), .int_n(int_n)
);
`default_nettype wire

/* File: tb/rcb_link_model.sv */
// line side and system side partner: sends a bit pattern with its own
// link clock and records the serial data and signaling outputs.
// assumes the bench fills pat before each run.
`timescale 1ns/1ps
`default_nettype none
module rcb_link_model (
  output var  logic lclk,
  output var  logic ldat,
  output var  logic mfs,
  input  wire logic dout,
  input  wire logic sout
);
  logic pat [0:4095];
  logic dat [0:4095];
  logic sig [0:4095];
  // ****************************************
  // link sender
  // ****************************************
  initial begin
    lclk = 1'b0;
    ldat = 1'b0;
    mfs  = 1'b0;
  end
  // 160 ns bit; outputs sampled on the falling edge, well after the
  // design's synchroniser delay; clock stands still between runs
  task automatic run(input int n);
    for (int i = 0; i < n; i++) begin
      ldat = pat[i];
      mfs  = (i == 0);
      #80 lclk = 1'b1;
      #80 lclk = 1'b0;
      dat[i] = dout;
      sig[i] = sout;
    end
    ldat = ~ldat; // no stale level once the frame ends
    mfs  = 1'b0;
  endtask : run
endmodule : rcb_link_model
`default_nettype wire

/* File: tb/tb.sv */
// self-checking bench for the receive signaling buffer.
// assumes rcb_top, the link partner and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import rcb_pkg::*;
  logic         aclk, aresetn, fsl, sml, slip;
  logic         lclk, ldat, mfs, dout, sout, int_n;
  rcb_axi_req_t req;
  rcb_axi_rsp_t rsp;
  int           mismatches, checks;
  logic [31:0]  v;
  logic [1:0]   r;

  always #5 aclk = ~aclk;

  rcb_top dut (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
    .rx_link_clk(lclk), .rx_line_data(ldat), .rx_mf_start(mfs),
    .frame_sync_lost(fsl), .smf_sync_lost(sml), .es_slip(slip),
    .rx_data_out(dout), .rx_signaling_out(sout), .int_n(int_n));
  rcb_link_model link (.lclk(lclk), .ldat(ldat), .mfs(mfs), .dout(dout), .sout(sout));

  // ****************************************
  // helpers
  // ****************************************
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task results;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results

  // address and data offered together, each released when taken
  task axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= d;
    req.wstrb   <= 4'hF;
    req.bready  <= 1'b1;
    // no cycle count assumed: only the watchdog ends a stuck wait
    do begin
      @(posedge aclk);
      if (rsp.awready && req.awvalid) req.awvalid <= 1'b0;
      if (rsp.wready && req.wvalid) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1);
    r = rsp.bresp;
    req.bready <= 1'b0;
  endtask : axw

  task axr(input logic [7:0] a);
    @(posedge aclk);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (rsp.arready && req.arvalid) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1);
    v = rsp.rdata;
    r = rsp.rresp;
    req.rready <= 1'b0;
  endtask : axr

  task bwait;
    do begin
      axr(REG_BUSY);
    end while (v[0] !== 1'b0);
  endtask : bwait

  task iw(input logic [6:0] a, input logic [7:0] d);
    axw(REG_ACC_DAT, {24'h000000, d});
    axw(REG_ACC_CTL, {25'h0000000, a});
    bwait;
  endtask : iw

  task ind(input logic [6:0] a, input logic [7:0] e);
    axw(REG_ACC_CTL, {24'h000000, 1'b1, a});
    bwait;
    axr(REG_ACC_DAT);
    chk("indirect word", v, {24'h000000, e});
  endtask : ind

  task fill(input int n);
    for (int i = 0; i < n; i++) link.pat[i] = i[0] ^ i[3];
  endtask : fill

  task put(input int b, input logic [7:0] c);
    for (int k = 0; k < 8; k++) link.pat[b+k] = c[7-k];
  endtask : put

  function automatic logic [7:0] grab(input int b);
    for (int k = 0; k < 8; k++) grab[7-k] = link.sig[b+k];
  endfunction : grab

  // ****************************************
  // scenarios
  // ****************************************
  task t_regs;
    chk("int_n", int_n, 1);
    axr(REG_COS_MSK);
    chk("mask", v, COS_MSK_RST);
    axr(8'h1C);
    chk("rresp", r, RESP_SLVERR);
    axw(8'h1C, 32'hFFFFFFFF);
    chk("bresp", r, RESP_SLVERR);
    iw(7'h19, 8'h8F);
    ind(7'h19, 8'h00);
  endtask : t_regs

  // superframe: ch1 extracts a=1 (frame 6) b=0 (frame 12), ch2 does not
  task t_t1;
    int e;
    e = 0;
    axw(REG_CFG, 32'h00000008);
    axw(REG_COS_MSK, 32'hFFFFFFFF);
    iw(7'h01, 8'h80);
    iw(7'h02, 8'h00);
    fill(2325);
    link.pat[973]  = 1'b1;
    link.pat[981]  = 1'b1;
    link.pat[2131] = 1'b0;
    link.pat[2139] = 1'b1;
    link.run(2325);
    repeat (4) @(posedge aclk);
    chk("int_n", int_n, 0);
    axr(REG_COS);
    chk("cos", v, 32'h00000002);
    repeat (3) @(posedge aclk);
    chk("int_n", int_n, 1);
    ind(7'h01, 8'h8A);
    ind(7'h02, 8'h00);
    chk("sig slot", grab(2317), 8'h0A);
    for (int i = 0; i < 2325; i++) if (link.dat[i] !== link.pat[i]) e++;
    chk("data", e, 0);
  endtask : t_t1

  // e1: frame 1 timeslot 16 carries ts1 code A and ts17 code 5
  task t_e1;
    // a mask bit at one lets its flag reach the interrupt
    axw(REG_CFG, 32'h00000018);
    axw(REG_COS_MSK, 32'h00000000);
    iw(7'h01, 8'h80);
    iw(7'h11, 8'h80);
    iw(7'h10, 8'h80);
    ind(7'h10, 8'h00);
    axr(REG_COS);
    fill(528);
    put(384, 8'hA5);
    link.run(528);
    ind(7'h01, 8'h8A);
    ind(7'h11, 8'h85);
    chk("sig slot", grab(520), 8'h0A);
    chk("int_n", int_n, 1);
    axw(REG_COS_MSK, 32'hFFFFFFFF);
    repeat (3) @(posedge aclk);
    chk("int_n", int_n, 0);
    axw(REG_COS, 32'h00000002);
    axr(REG_COS);
    chk("cos", v, 32'h00020000);
  endtask : t_e1

  // new code only lands when seen twice in a row
  task t_deb;
    axw(REG_CFG, 32'h00000019);
    for (int j = 0; j < 2; j++) begin
      fill(400);
      put(384, 8'h35);
      link.run(400);
      ind(7'h01, j ? 8'h83 : 8'h8A);
    end
    // flag from the second run is up; dropping the enable must quiet the pin
    chk("int_n", int_n, 0);
    axw(REG_CFG, 32'h00000011);
    repeat (2) @(posedge aclk);
    chk("int_n", int_n, 1);
  endtask : t_deb

  // freeze by software bit, frame loss, multiframe loss, slip; then none
  task t_frz;
    axw(REG_CFG, 32'h00000018);
    for (int k = 0; k < 5; k++) begin
      if (k == 0) axw(REG_CFG, 32'h0000001A);
      @(posedge aclk);
      fsl <= (k == 1);
      sml <= (k == 2);
      repeat (8) @(posedge aclk);
      fill(400);
      put(384, 8'hFF);
      fork
        link.run(400);
        if (k == 3) begin
          repeat (200) @(posedge aclk);
          slip <= 1'b1;
          repeat (3) @(posedge aclk);
          slip <= 1'b0;
        end
      join
      @(posedge aclk);
      fsl <= 1'b0;
      sml <= 1'b0;
      axw(REG_CFG, 32'h00000018);
      ind(7'h01, (k < 4) ? 8'h83 : 8'h8F);
    end
  endtask : t_frz

  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    req = '0;
    fsl = 1'b0;
    sml = 1'b0;
    slip = 1'b0;
    mismatches = 0;
    checks = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_t1;
    t_e1;
    t_deb;
    t_frz;
    results;
  end

  // runs take about 91k cycles; stop a hang before 100k
  initial begin
    #990000;
    mismatches++;
    results;
  end
endmodule : tb
`default_nettype wire
